// ==== logic/tpst_buffer.sv ====
// Purpose: Two-entry valid/ready buffer between the bus and the sequencer
// Assumes: Single clock, reset already synchronised
// Notes: Full and empty come straight from the entry count
`timescale 1ns/1ps
`default_nettype none
module tpst_buffer #(
  parameter int WIDTH = tpst_pkg::BUF_WIDTH,
  parameter int DEPTH = tpst_pkg::BUF_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0] level
);
  import tpst_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic push;
  logic pop;

  // Honest full and empty, so a stalled drain really backs up the source
  assign in_ready = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign level = cnt_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage written at the write index
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
    end
  end

  // Entry count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
    end
    else if (push && !pop)
    begin
      cnt_q <= cnt_q + CW'(1);
    end
    else if (pop && !push)
    begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

endmodule
`default_nettype wire

// ==== logic/tpst_pkg.sv ====
// Purpose: Shared constants and types for the timer paced serial transmitter
// Assumes: 50 MHz system clock, APB register access
// Notes: Timing derived from the bit timer tick and the clock period
package tpst_pkg;

  // Clock and line timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int TIMER_SRC_HZ = 8000000;
  localparam int TIMER_PRESCALE = 32;
  localparam int BAUD_RATE = 9600;
  localparam int BIT_TIME_US = 104;
  localparam int TICK_NS = (TIMER_PRESCALE * 1000) / (TIMER_SRC_HZ / 1000000);
  localparam int PRE_CYCLES_INT = TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0] PRE_LAST = 8'(PRE_CYCLES_INT - 1);
  localparam logic [4:0] BIT_TICKS_LAST = 5'h19;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [7:0] FIRST_MASK = 8'h01;

  // Bit timer status/control image
  localparam logic [7:0] TSC_RESET = 8'h10;
  localparam logic [7:0] TSC_CLEAR_CMD = 8'h60;
  localparam int TSC_OVF_POS = 7;
  localparam int TSC_RST_POS = 5;
  localparam int TSC_STOP_POS = 4;

  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_TIMER = 8'h0c;
  localparam logic [7:0] ADDR_FRAMES = 8'h10;

  // Control field positions and reset value
  localparam int CTRL_DIR_POS = 0;
  localparam int CTRL_LVL_POS = 1;
  localparam int CTRL_EN_POS = 2;
  localparam logic [2:0] CTRL_RESET = 3'h7;

  // Buffer shape
  localparam int BUF_WIDTH = 8;
  localparam int BUF_DEPTH = 2;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } tpst_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tpst_apb_rsp_type;

  typedef struct packed {
    logic tx_line_pin_o;
    logic tx_line_pin_oe;
    logic busy;
  } tpst_line_type;

endpackage

// ==== logic/tpst_top.sv ====
// Purpose: Transmit-only asynchronous serial port paced by a modulo bit timer
// Assumes: 50 MHz sys_clk, APB slave for software, receiver on the far end
// Notes: Frame is start, 8 data bits LSB first, stop, then one idle gap cell
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tpst_top (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // APB slave
  input wire tpst_pkg::tpst_apb_req_type apb_req,
  output tpst_pkg::tpst_apb_rsp_type apb_rsp,
  // Serial line
  output tpst_pkg::tpst_line_type line
);
  import tpst_pkg::*;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_START = 5'b00010,
    ST_DATA = 5'b00100,
    ST_STOP = 5'b01000,
    ST_GAP = 5'b10000
  } tpst_state_type;

  // Apply a write to the timer status/control image
  function automatic logic [7:0] tsc_write(input logic [7:0] cmd);
    logic [7:0] v;
    v = cmd;
    v[TSC_OVF_POS] = 1'b0;
    v[TSC_RST_POS] = 1'b0;
    return v;
  endfunction

  logic rst_meta_q;
  logic rst_n;
  tpst_state_type state_q;
  logic [2:0] ctrl_q;
  logic [7:0] tsc_q;
  logic [7:0] pre_q;
  logic [4:0] tick_q;
  logic [3:0] bits_left_q;
  logic [7:0] mask_q;
  logic [7:0] byte_q;
  logic line_q;
  logic [15:0] frames_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_val;
  logic pre_wrap;
  logic ovf_evt;
  logic ovf_seen;
  logic tx_start;
  logic timer_cmd;
  logic setup;
  logic access;
  logic mapped;
  logic data_wr;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [7:0] buf_out_data;
  logic [1:0] buf_level;

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // APB phase decode
  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable;
  assign mapped = (apb_req.paddr == ADDR_CTRL) | (apb_req.paddr == ADDR_DATA) |
                  (apb_req.paddr == ADDR_STATUS) | (apb_req.paddr == ADDR_TIMER) |
                  (apb_req.paddr == ADDR_FRAMES);
  assign data_wr = access & apb_req.pwrite & (apb_req.paddr == ADDR_DATA);

  // A data write waits while both buffer entries are in use
  assign apb_rsp.pready = access & (~data_wr | buf_in_ready);
  assign apb_rsp.pslverr = access & ~mapped;
  assign apb_rsp.prdata = prdata_q;
  assign buf_in_valid = data_wr;

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rd_val = '0;
    unique case (apb_req.paddr)
      ADDR_CTRL: rd_val = {29'h0000000, ctrl_q};
      ADDR_DATA: rd_val = {24'h000000, byte_q};
      ADDR_STATUS: rd_val = {28'h0000000, buf_level, line_q, ~state_q[0]};
      ADDR_TIMER: rd_val = {11'h000, tick_q, pre_q, tsc_q};
      ADDR_FRAMES: rd_val = {16'h0000, frames_q};
      default: rd_val = '0;
    endcase
  end

  // Read data latched in setup so the answer comes from a flop
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_q <= '0;
    end
    else if (setup)
    begin
      prdata_q <= apb_req.pwrite ? 32'h00000000 : rd_val;
    end
  end

  // Control register: direction, idle level, transmit enable
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (access && apb_req.pwrite && apb_req.paddr == ADDR_CTRL)
    begin
      ctrl_q <= apb_req.pwdata[2:0];
    end
  end

  tpst_buffer #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(apb_req.pwdata[7:0]),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data),
    .level(buf_level)
  );

  // Only an idle, enabled output takes the next byte
  assign buf_out_ready = state_q[0] & ctrl_q[CTRL_EN_POS] & ctrl_q[CTRL_DIR_POS];
  assign tx_start = buf_out_valid & buf_out_ready;

  // Prescaler wraps every 4 us worth of sys_clk cycles
  assign pre_wrap = ~tsc_q[TSC_STOP_POS] & (pre_q == PRE_LAST);
  assign ovf_evt = pre_wrap & (tick_q == BIT_TICKS_LAST);
  // Sequencer answers a pending overflow with the clear command
  assign ovf_seen = tsc_q[TSC_OVF_POS] & ~state_q[0];
  assign timer_cmd = ovf_seen | tx_start;

  // Prescaler and tick counter; a command restarts both from zero
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_q <= '0;
      tick_q <= '0;
    end
    else if (timer_cmd || tsc_q[TSC_STOP_POS])
    begin
      pre_q <= '0;
      tick_q <= '0;
    end
    else if (pre_wrap)
    begin
      pre_q <= '0;
      tick_q <= (tick_q == BIT_TICKS_LAST) ? '0 : tick_q + 5'h01;
    end
    else
    begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // Status/control image; a new overflow beats a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tsc_q <= TSC_RESET;
    end
    else
    begin
      if (timer_cmd)
      begin
        tsc_q <= tsc_write(TSC_CLEAR_CMD);
      end
      else if (state_q[0])
      begin
        tsc_q <= TSC_RESET; // Stopped while idle, saves power
      end
      if (ovf_evt)
      begin
        tsc_q[TSC_OVF_POS] <= 1'b1;
      end
    end
  end

  // Frame sequencer: leaves idle on a start; each later cell waits for one overflow
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (tx_start)
          begin
            state_q <= ST_START;
          end
        end
        ST_START:
        begin
          if (ovf_seen)
          begin
            state_q <= ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (ovf_seen && bits_left_q == 4'h1)
          begin
            state_q <= ST_STOP;
          end
        end
        ST_STOP:
        begin
          if (ovf_seen)
          begin
            state_q <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          if (ovf_seen)
          begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Byte holder, bit counter and walking mask
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_q <= '0;
      bits_left_q <= '0;
      mask_q <= FIRST_MASK;
    end
    else if (tx_start)
    begin
      byte_q <= buf_out_data;
      bits_left_q <= DATA_BITS;
      mask_q <= FIRST_MASK;
    end
    else if (ovf_seen && state_q == ST_DATA)
    begin
      bits_left_q <= bits_left_q - 4'h1;
      mask_q <= {mask_q[6:0], 1'b0};
    end
  end

  // Line level changes only on a start, an answered overflow, or while idle to follow the idle level
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_q <= 1'b1;
    end
    else if (tx_start)
    begin
      line_q <= 1'b0;
    end
    else if (ovf_seen)
    begin
      if (state_q == ST_START || (state_q == ST_DATA && bits_left_q != 4'h1))
      begin
        // Next data bit; mask already points at it for the start cell
        line_q <= |(byte_q & (state_q == ST_START ? mask_q : {mask_q[6:0], 1'b0}));
      end
      else
      begin
        line_q <= 1'b1;
      end
    end
    else if (state_q[0])
    begin
      line_q <= ctrl_q[CTRL_LVL_POS];
    end
  end

  // Completed frame counter, wraps
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frames_q <= '0;
    end
    else if (ovf_seen && state_q == ST_GAP)
    begin
      frames_q <= frames_q + 16'h0001;
    end
  end

  // Pin drive; one extra cycle per cell keeps error near 0.14 percent
  assign line.tx_line_pin_o = line_q;
  assign line.tx_line_pin_oe = ctrl_q[CTRL_DIR_POS];
  assign line.busy = ~state_q[0];

endmodule
`default_nettype wire

// ==== sim/timer_paced_serial_transmitter_tb.sv ====
// Purpose: Self-checking bench for the serial transmitter
// Assumes: Receiver model on the line, APB master here
// Notes: One full frame plus a stalled write fits the run length
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin fails++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module timer_paced_serial_transmitter_tb;
  import tpst_pkg::*;
  logic sys_clk;
  logic arst_n;
  tpst_apb_req_type req;
  tpst_apb_rsp_type rsp;
  tpst_line_type line;
  logic [31:0] q;
  logic e;
  logic [7:0] b [4];
  logic [7:0] rx_data;
  logic [7:0] rx_count;
  logic rx_err;
  int fails;
  int comparisons;
  int wait_n;
  tpst_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
    .line(line));
  tpst_rx_model u_rx (.clk(sys_clk), .line_i(line.tx_line_pin_o), .rx_data(rx_data),
    .rx_count(rx_count), .frame_err(rx_err));
  // Expected status word
  function automatic logic [31:0] status_of(logic bz, logic lv, logic [1:0] n);
    return {28'h0, n, lv, bz};
  endfunction
  // One APB transfer; idle cycle after so signals never change twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge sys_clk);
    req.penable <= 1'b1;
    wait_n = 0;
    @(posedge sys_clk);
    while (rsp.pready !== 1'b1)
    begin
      @(posedge sys_clk);
      wait_n++;
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Watchdog sized above one frame plus a stalled write
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    fails++;
    summarize();
  end
  initial
  begin
    arst_n = 1'b0;
    req = '0;
    fails = 0;
    comparisons = 0;
    void'($urandom(32'h2b21));
    b[0] = 8'($urandom);
    b[1] = 8'h00;
    b[2] = 8'hff;
    b[3] = 8'($urandom);
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl", 32'(CTRL_RESET), q)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("idle status", status_of(1'b0, 1'b1, 2'h0), q)
    apb(1'b0, ADDR_TIMER, 32'h0);
    `CHK("timer image", TSC_RESET, q[7:0])
    apb(1'b0, 8'h14 + 8'($urandom % 8) * 8'h4, 32'h0);
    `CHK("unmapped", {1'b1, 32'h0}, {e, q})
    // Disabled sender keeps the byte queued and the line at rest
    apb(1'b1, ADDR_CTRL, 32'((1 << CTRL_DIR_POS) | (1 << CTRL_LVL_POS)));
    apb(1'b0, ADDR_CTRL, 32'h0);
    `CHK("ctrl held", 32'((1 << CTRL_DIR_POS) | (1 << CTRL_LVL_POS)), q)
    apb(1'b1, ADDR_DATA, 32'(b[0]));
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("held status", status_of(1'b0, 1'b1, 2'h1), q)
    apb(1'b1, ADDR_CTRL, 32'(CTRL_RESET));
    for (int i = 1; i < 3; i++)
      apb(1'b1, ADDR_DATA, 32'(b[i]));
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("full status", status_of(1'b1, 1'b0, 2'h2), q & 32'hfffffffd)
    apb(1'b1, ADDR_DATA, 32'(b[3]));
    `CHK("write stalled", 1'b1, wait_n > 40000)
    `CHK("frames seen", 8'h1, rx_count)
    `CHK("byte", b[0], rx_data)
    `CHK("stop ok", 1'b0, rx_err)
    // Second frame has just begun with the next queued byte
    apb(1'b0, ADDR_DATA, 32'h0);
    `CHK("byte in flight", 32'(b[1]), q)
    apb(1'b0, ADDR_TIMER, 32'h0);
    `CHK("timer running", TSC_CLEAR_CMD & ~(8'h1 << TSC_RST_POS), q[7:0])
    apb(1'b0, ADDR_FRAMES, 32'h0);
    `CHK("frame count", 32'h1, q)
    summarize();
  end
endmodule
`default_nettype wire

// ==== sim/tpst_checker.sv ====
// Purpose: Line timing and bus answer checks for the transmitter
// Assumes: Sees only the top ports
// Notes: A cell is 26 ticks plus the one clear cycle
`timescale 1ns/1ps
`default_nettype none
module tpst_checker
  import tpst_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Bus and line
  input wire tpst_pkg::tpst_apb_req_type apb_req,
  input wire tpst_pkg::tpst_apb_rsp_type apb_rsp,
  input wire tpst_pkg::tpst_line_type line
);
  localparam int CELL = (int'(BIT_TICKS_LAST) + 1) * PRE_CYCLES_INT + 1;
  logic [15:0] cell_q;
  logic [15:0] frame_q;
  logic mapped;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Address decode
  assign mapped = apb_req.paddr inside {ADDR_CTRL, ADDR_DATA, ADDR_STATUS, ADDR_TIMER,
    ADDR_FRAMES};
  // Position in cell and frame; cleared while idle so each frame starts at zero
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n)
    begin
      cell_q <= 16'h0;
      frame_q <= 16'h0;
    end
    else
    begin
      cell_q <= (!line.busy || cell_q == 16'(CELL - 1)) ? 16'h0 : cell_q + 16'h1;
      frame_q <= line.busy ? frame_q + 16'h1 : 16'h0;
    end
  sequence s_start;
    !line.busy ##1 line.busy;
  endsequence
  sequence s_acc;
    apb_req.psel && apb_req.penable;
  endsequence
  AST_START: assert property (s_start |-> !line.tx_line_pin_o && line.tx_line_pin_oe)
    else $error("start bit not low at frame start");
  AST_START_CELL: assert property (line.busy && frame_q < 16'(CELL) |-> !line.tx_line_pin_o)
    else $error("start cell not held low");
  AST_EDGE: assert property (line.busy && $past(line.busy) && $changed(line.tx_line_pin_o)
    |-> cell_q == 16'h0)
    else $error("line moved inside a cell");
  AST_TAIL: assert property (line.busy && frame_q >= 16'(9 * CELL) |-> line.tx_line_pin_o)
    else $error("stop or gap cell not high");
  AST_LEN: assert property ($fell(line.busy) |-> frame_q == 16'(11 * CELL))
    else $error("frame length wrong");
  AST_IDLE: assert property (!line.busy |-> line.tx_line_pin_o)
    else $error("idle line not high");
  AST_OE: assert property (line.busy |-> line.tx_line_pin_oe)
    else $error("pin not driven during frame");
  AST_READY: assert property (s_acc ##0 !(apb_req.pwrite && apb_req.paddr == ADDR_DATA)
    |-> apb_rsp.pready)
    else $error("access not answered at once");
  AST_ERR: assert property (s_acc |-> apb_rsp.pslverr == !mapped)
    else $error("error flag wrong for address");
  AST_ERR_DATA: assert property (s_acc ##0 !mapped |-> apb_rsp.prdata == 32'h0)
    else $error("unmapped read data not zero");
endmodule
bind tpst_top tpst_checker u_chk (.sys_clk(sys_clk), .arst_n(arst_n), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .line(line));
`default_nettype wire

// ==== sim/tpst_rx_model.sv ====
// Purpose: Remote serial receiver sampling each cell in its middle
// Assumes: Line rests high, cell length given in clocks
// Notes: A start that is high at mid cell flags a frame error
`timescale 1ns/1ps
`default_nettype none
module tpst_rx_model #(
  parameter int CELL = 5201
) (
  // Clock and line
  input wire logic clk,
  input wire logic line_i,
  // Received result
  output logic [7:0] rx_data,
  output logic [7:0] rx_count,
  output logic frame_err
);
  int cnt;
  int bitn;
  logic prev;
  logic [7:0] sh;
  initial
  begin
    cnt = 0;
    bitn = -1;
    prev = 1'b1;
    sh = 8'h0;
    rx_data = 8'h0;
    rx_count = 8'h0;
    frame_err = 1'b0;
  end
  // Edge hunt, then one sample per cell
  always @(posedge clk)
  begin
    prev <= line_i;
    if (bitn < 0)
    begin
      if (prev && !line_i)
      begin
        bitn <= 0;
        cnt <= CELL / 2;
      end
    end
    else if (cnt != 0)
      cnt <= cnt - 1;
    else
    begin
      cnt <= CELL - 1;
      bitn <= bitn + 1;
      if (bitn == 0 && line_i)
      begin
        frame_err <= 1'b1;
        bitn <= -1;
      end
      else if (bitn >= 1 && bitn <= 8)
        sh <= {line_i, sh[7:1]};
      else if (bitn == 9)
      begin
        rx_data <= sh;
        rx_count <= rx_count + 8'h1;
        frame_err <= frame_err | !line_i;
        bitn <= -1;
      end
    end
  end
endmodule
`default_nettype wire
